//--- hw/crspc_power_ctrl.sv
// Purpose: pci clock-run handshake, card clock stop, 16-bit card output
//   control and suspend gating
// Assumes: clk_i is the pci clock, card_clk_i the free card link clock
// Notes: ring wake and status-change outputs are clockless paths
// Behaviour
// - keep bit set keeps and restarts clock
// - refuse stop while 16-bit manager busy
// - refuse stop while card-side master busy
// - refuse stop while pci master busy
// - pending interrupt refuses stop, requests restart
// - refuse stop while any card clock runs
// - refuse stop during new card interrogation
// - card interrupt requests pci clock restart
// - status-change, wake or ring requests restart
// - card clock restart or bus request restarts
// - data in any buffer requests restart
// - busy master state machine requests restart
// - clock-run driven on multifunction pin six
// - idle card clock stopped via card clock-run
// - output disable floats and resets 16-bit card
// - auto powerdown floats idle card, no reset
// - suspend blocks both resets, gates pci clock
// - suspended resets keep register contents
// - suspend floats outputs after current transaction
// - pins and ring wake stay active in suspend
// - status change and ring wake need no clock
`timescale 1ns/100ps
`include "crspc_cfg.svh"
module crspc_power_ctrl
  import crspc_pkg::*;
#(
  parameter int SOCKETS = `CRSPC_SOCKETS,
  parameter int HOLD_CYC = `CRSPC_REFUSE_HOLD_CYC,
  parameter int IDLE_CYC = `CRSPC_CARD_IDLE_CYC,
  parameter int ASK_CYC = `CRSPC_CARD_ASK_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic card_clk_i,
  input wire logic keep_pci_clock_bit_i,
  input wire logic r16_busy_i,
  input wire logic cb_master_busy_i,
  input wire logic pci_master_busy_i,
  input wire logic posted_data_i,
  input wire logic irq_pending_i,
  input wire logic interrogating_i,
  input wire logic fifo_data_i,
  input wire logic mstate_busy_i,
  input wire logic multifunction_pin_six_i,
  output logic multifunction_pin_six_o,
  output logic multifunction_pin_six_oe_o,
  input wire logic [SOCKETS-1:0] card_irq_i,
  input wire logic [SOCKETS-1:0] card_wake_status_i,
  input wire logic [SOCKETS-1:0] ring_i,
  input wire logic [SOCKETS-1:0] ring_enable_i,
  input wire logic [SOCKETS-1:0] cclkrun_i,
  output logic [SOCKETS-1:0] cclkrun_o,
  output logic [SOCKETS-1:0] cclkrun_oe_o,
  input wire logic [SOCKETS-1:0] creq_n_i,
  output logic [SOCKETS-1:0] card_clk_en_o,
  input wire logic [SOCKETS-1:0] card_output_disable_i,
  input wire logic [SOCKETS-1:0] auto_card_powerdown_i,
  input wire logic [SOCKETS-1:0] card16_idle_i,
  output logic [SOCKETS-1:0] card16_float_o,
  output logic [SOCKETS-1:0] card16_reset_o,
  input wire logic suspend_i,
  input wire logic pci_reset_in_i,
  input wire logic global_reset_in_i,
  input wire logic gnt_n_i,
  input wire logic pci_txn_i,
  output logic core_reset_o,
  output logic pci_clk_gate_o,
  output logic pci_out_float_o,
  output logic ring_wake_out_o,
  output logic csc_async_o
);

  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam int AW = $clog2(ASK_CYC + 1);

  // pin synchronisers, pci domain
  logic cr_meta_reg;
  logic cr_sync_reg;
  logic [SOCKETS-1:0] irq_meta_reg;
  logic [SOCKETS-1:0] irq_sync_reg;
  logic [SOCKETS-1:0] wake_meta_reg;
  logic [SOCKETS-1:0] wake_sync_reg;
  logic [SOCKETS-1:0] ring_meta_reg;
  logic [SOCKETS-1:0] ring_sync_reg;
  logic [4:0] sys_meta_reg;
  logic [4:0] sys_sync_reg;
  logic susp_s;
  logic pci_rst_s;
  logic glob_rst_s;
  logic txn_s;

  // crossings from the link domain
  logic [SOCKETS-1:0] run_meta_reg;
  logic [SOCKETS-1:0] run_sync_reg;
  logic [SOCKETS-1:0] wtgl_meta_reg;
  logic [SOCKETS-1:0] wtgl_sync_reg;
  logic [SOCKETS-1:0] wtgl_seen_reg;
  logic [SOCKETS-1:0] wake_tgl_reg;
  // crossing into the link domain
  logic act_src_reg;
  logic [SOCKETS-1:0] act_meta_reg;
  logic [SOCKETS-1:0] act_sync_reg;

  logic refuse_stop;
  logic want_restart;
  logic keep_clk;
  logic card_restart_evt;
  crspc_clkrun_e cr_state_reg;
  logic [HW-1:0] hold_cnt_reg;
  logic cr_drive;
  logic susp_active_reg;

  // two-flop capture of every outside pin in the pci domain
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cr_meta_reg <= 1'b1;
      cr_sync_reg <= 1'b1;
      irq_meta_reg <= '0;
      irq_sync_reg <= '0;
      wake_meta_reg <= '0;
      wake_sync_reg <= '0;
      ring_meta_reg <= '0;
      ring_sync_reg <= '0;
      sys_meta_reg <= 5'h10;
      sys_sync_reg <= 5'h10;
    end
    else
    begin
      cr_meta_reg <= multifunction_pin_six_i;
      cr_sync_reg <= cr_meta_reg;
      irq_meta_reg <= card_irq_i;
      irq_sync_reg <= irq_meta_reg;
      wake_meta_reg <= card_wake_status_i;
      wake_sync_reg <= wake_meta_reg;
      ring_meta_reg <= ring_i;
      ring_sync_reg <= ring_meta_reg;
      sys_meta_reg <= {gnt_n_i, pci_txn_i, global_reset_in_i,
                       pci_reset_in_i, suspend_i};
      sys_sync_reg <= sys_meta_reg;
    end
  end

  // grant and transaction are combined only after their synchronisers
  assign susp_s = sys_sync_reg[0];
  assign pci_rst_s = sys_sync_reg[1];
  assign glob_rst_s = sys_sync_reg[2];
  assign txn_s = sys_sync_reg[3] & ~sys_sync_reg[4];

  // card clock state and wake toggles brought into the pci domain
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_meta_reg <= '0;
      run_sync_reg <= '0;
      wtgl_meta_reg <= '0;
      wtgl_sync_reg <= '0;
      wtgl_seen_reg <= '0;
      act_src_reg <= 1'b0;
    end
    else
    begin
      run_meta_reg <= card_clk_en_o;
      run_sync_reg <= run_meta_reg;
      wtgl_meta_reg <= wake_tgl_reg;
      wtgl_sync_reg <= wtgl_meta_reg;
      wtgl_seen_reg <= wtgl_sync_reg;
      // one flop, so the link side never sees a glitching or
      act_src_reg <= cb_master_busy_i | mstate_busy_i;
    end
  end

  assign card_restart_evt = |(wtgl_sync_reg ^ wtgl_seen_reg);

  // reasons to refuse a stop and to ask for a restart
  assign refuse_stop = keep_pci_clock_bit_i
                     | r16_busy_i
                     | cb_master_busy_i
                     | pci_master_busy_i | posted_data_i
                     | irq_pending_i
                     | (|run_sync_reg)
                     | interrogating_i;
  assign want_restart = (|irq_sync_reg)
                      | (|wake_sync_reg)
                      | (|(ring_sync_reg & ring_enable_i))
                      | card_restart_evt
                      | keep_pci_clock_bit_i | irq_pending_i
                      | fifo_data_i
                      | mstate_busy_i;
  assign keep_clk = refuse_stop | want_restart;

  // host clock-run handshake: a high line means stop asked or clock off,
  // so the pin is pulled low for the hold time and released again
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cr_state_reg <= CR_IDLE;
      hold_cnt_reg <= '0;
    end
    else
    begin
      unique case (cr_state_reg)
        CR_IDLE:
        begin
          if (cr_sync_reg && keep_clk)
          begin
            cr_state_reg <= CR_HOLD;
            hold_cnt_reg <= '0;
          end
        end
        CR_HOLD:
        begin
          hold_cnt_reg <= hold_cnt_reg + 1'b1;
          if (hold_cnt_reg == HW'(HOLD_CYC - 1))
            cr_state_reg <= CR_WAIT;
        end
        CR_WAIT:
        begin
          if (!cr_sync_reg) // host owns the low level again
            cr_state_reg <= CR_IDLE;
        end
        default: cr_state_reg <= CR_IDLE;
      endcase
    end
  end

  assign cr_drive = (cr_state_reg == CR_HOLD);
  // open-drain drive on pin six, works also in suspend
  assign multifunction_pin_six_o = 1'b0;
  assign multifunction_pin_six_oe_o = cr_drive;

  // suspend takes effect only once no granted transaction runs
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      susp_active_reg <= 1'b0;
    else if (!susp_s)
      susp_active_reg <= 1'b0;
    else if (!txn_s)
      susp_active_reg <= 1'b1;
  end

  // gated reset, clock gate and float controls
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      core_reset_o <= 1'b1;
      pci_clk_gate_o <= 1'b0;
      pci_out_float_o <= 1'b0;
    end
    else
    begin
      // resets blocked in suspend so registers keep their contents
      core_reset_o <= (pci_rst_s | glob_rst_s) & ~susp_s;
      pci_clk_gate_o <= susp_active_reg;
      pci_out_float_o <= susp_active_reg;
    end
  end

  // 16-bit card output disable and automatic powerdown
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      card16_float_o <= '0;
      card16_reset_o <= '0;
    end
    else
    begin
      card16_float_o <= card_output_disable_i
                      | (auto_card_powerdown_i & card16_idle_i);
      card16_reset_o <= card_output_disable_i;
    end
  end

  // clockless paths for wake and status change
  assign ring_wake_out_o = |((ring_i & ring_enable_i)
                             | card_wake_status_i);
  assign csc_async_o = |card_wake_status_i;

  // card-side activity crossing into the link domain
  always_ff @(posedge card_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      act_meta_reg <= '0;
      act_sync_reg <= '0;
    end
    else
    begin
      act_meta_reg <= {SOCKETS{act_src_reg}};
      act_sync_reg <= act_meta_reg;
    end
  end

  // per-socket card clock manager on the card link clock
  for (genvar s = 0; s < SOCKETS; s++)
  begin : g_sock
    logic ccr_meta_reg;
    logic ccr_sync_reg;
    logic req_meta_reg;
    logic req_sync_reg;
    logic card_wants;
    crspc_cclk_e cc_state_reg;
    logic [IW-1:0] idle_cnt_reg;
    logic [AW-1:0] ask_cnt_reg;

    // two-flop capture of the card pins
    always_ff @(posedge card_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        ccr_meta_reg <= 1'b1;
        ccr_sync_reg <= 1'b1;
        req_meta_reg <= 1'b1;
        req_sync_reg <= 1'b1;
      end
      else
      begin
        ccr_meta_reg <= cclkrun_i[s];
        ccr_sync_reg <= ccr_meta_reg;
        req_meta_reg <= creq_n_i[s];
        req_sync_reg <= req_meta_reg;
      end
    end

    assign card_wants = ~req_sync_reg | act_sync_reg[s];

    // run, ask the card, then stop the clock unless it objects
    always_ff @(posedge card_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        cc_state_reg <= CC_RUN;
        idle_cnt_reg <= '0;
        ask_cnt_reg <= '0;
        wake_tgl_reg[s] <= 1'b0;
      end
      else
      begin
        unique case (cc_state_reg)
          CC_RUN:
          begin
            if (card_wants)
              idle_cnt_reg <= '0;
            else if (idle_cnt_reg == IW'(IDLE_CYC - 1))
            begin
              cc_state_reg <= CC_ASK;
              ask_cnt_reg <= '0;
            end
            else
              idle_cnt_reg <= idle_cnt_reg + 1'b1;
          end
          CC_ASK:
          begin
            ask_cnt_reg <= ask_cnt_reg + 1'b1;
            // the released line needs two synchroniser edges to show
            if (card_wants || (!ccr_sync_reg && ask_cnt_reg > AW'(2)))
            begin
              cc_state_reg <= CC_RUN;
              idle_cnt_reg <= '0;
            end
            else if (ask_cnt_reg == AW'(ASK_CYC - 1))
              cc_state_reg <= CC_STOP;
          end
          CC_STOP:
          begin
            if (card_wants || !ccr_sync_reg)
            begin
              cc_state_reg <= CC_RUN;
              idle_cnt_reg <= '0;
              wake_tgl_reg[s] <= ~wake_tgl_reg[s];
            end
          end
          default: cc_state_reg <= CC_RUN;
        endcase
      end
    end

    // card clock-run: host drives low while running, releases to ask
    always_ff @(posedge card_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        cclkrun_oe_o[s] <= 1'b1;
        card_clk_en_o[s] <= 1'b1;
      end
      else
      begin
        cclkrun_oe_o[s] <= (cc_state_reg == CC_RUN);
        card_clk_en_o[s] <= (cc_state_reg != CC_STOP);
      end
    end
    assign cclkrun_o[s] = 1'b0;

    // once asked and unanswered, the clock stops in a bounded time
    a_card_clk_stop: assert property (
      @(posedge card_clk_i) disable iff (rst_i)
      (cc_state_reg == CC_ASK && ask_cnt_reg == AW'(ASK_CYC - 1)
       && !card_wants && (ccr_sync_reg || ask_cnt_reg <= AW'(2)))
      |=> ##1 !card_clk_en_o[s])
      else $error("card clock not stopped after unanswered ask");
  end

  // pci clock checks; the card clock has its own above, so no default
  sequence s_stop_seen;
    cr_state_reg == CR_IDLE && cr_sync_reg;
  endsequence
  sequence s_refuse_pulse;
    multifunction_pin_six_oe_o [*2] ##1 !multifunction_pin_six_oe_o;
  endsequence

  a_keep_bit_refuse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_stop_seen ##0 keep_pci_clock_bit_i |=> s_refuse_pulse)
    else $error("keep bit did not hold the clock-run line");
  a_busy_refuse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_stop_seen ##0 (r16_busy_i || cb_master_busy_i || pci_master_busy_i
    || posted_data_i || interrogating_i) |=> s_refuse_pulse)
    else $error("busy condition did not refuse clock stop");
  a_irq_refuse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_stop_seen ##0 irq_pending_i |=> multifunction_pin_six_oe_o)
    else $error("pending interrupt did not refuse clock stop");
  a_card_clk_refuse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_stop_seen ##0 (|run_sync_reg) |=> multifunction_pin_six_oe_o)
    else $error("running card clock did not refuse stop");
  a_event_restart: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_stop_seen ##0 ((|irq_sync_reg) || (|wake_sync_reg) || fifo_data_i
    || mstate_busy_i) |=> multifunction_pin_six_oe_o)
    else $error("restart event did not request the clock");
  a_quiet_release: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cr_state_reg == CR_IDLE && !keep_clk |=> !multifunction_pin_six_oe_o)
    else $error("clock-run driven with no reason");
  a_disable_float_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    card_output_disable_i[0] |=> card16_float_o[0] && card16_reset_o[0])
    else $error("output disable did not float and reset card");
  a_powerdown_no_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    auto_card_powerdown_i[0] && card16_idle_i[0]
    && !card_output_disable_i[0] |=> card16_float_o[0] && !card16_reset_o[0])
    else $error("auto powerdown wrong on idle card");
  a_suspend_reset_blk: assert property (
    @(posedge clk_i) disable iff (rst_i)
    susp_s && $past(susp_s) |=> !core_reset_o)
    else $error("reset passed through during suspend");
  a_suspend_defer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !susp_active_reg && txn_s |=> !pci_out_float_o [*2])
    else $error("outputs floated during a granted transaction");

endmodule // crspc_power_ctrl

//--- hw/crspc_cfg.svh
// Purpose: constants of the clock-run, suspend and card power control
// Assumes: pci clock at 200 MHz, card link clock at about 6 ns
// Notes: times in ns, cycle counts derived from them
`ifndef CRSPC_CFG_SVH
`define CRSPC_CFG_SVH
`define CRSPC_PCI_PERIOD_NS 5
`define CRSPC_LINK_PERIOD_NS 6
// least time the clock-run pin is held low to refuse a stop
`define CRSPC_REFUSE_HOLD_NS 10
`define CRSPC_REFUSE_HOLD_CYC \
  ((`CRSPC_REFUSE_HOLD_NS + `CRSPC_PCI_PERIOD_NS - 1) / `CRSPC_PCI_PERIOD_NS)
// card idle time before the card clock stop is asked
`define CRSPC_CARD_IDLE_NS 960
`define CRSPC_CARD_IDLE_CYC \
  ((`CRSPC_CARD_IDLE_NS + `CRSPC_LINK_PERIOD_NS - 1) / `CRSPC_LINK_PERIOD_NS)
// window in which the card may object to the stop
`define CRSPC_CARD_ASK_NS 48
`define CRSPC_CARD_ASK_CYC \
  ((`CRSPC_CARD_ASK_NS + `CRSPC_LINK_PERIOD_NS - 1) / `CRSPC_LINK_PERIOD_NS)
`define CRSPC_SOCKETS 2
`endif

//--- hw/crspc_pkg.sv
// Purpose: types of the clock-run, suspend and card power control
// Assumes: nothing beyond the constants header
// Notes: state codes are gray along the forward path; the return from the last state to the first flips both bits
package crspc_pkg;
  // host clock-run handshake states
  typedef enum logic [1:0]
  {
    CR_IDLE = 2'b00,
    CR_HOLD = 2'b01,
    CR_WAIT = 2'b11
  } crspc_clkrun_e;
  // per-socket card clock manager states
  typedef enum logic [1:0]
  {
    CC_RUN = 2'b00,
    CC_ASK = 2'b01,
    CC_STOP = 2'b11
  } crspc_cclk_e;
endpackage

//--- test/crspc_far_model.sv
// Purpose: far-side model of the clock-run central resource and card lines
// Assumes: pin six and every card clock-run line have pull-ups
// Notes: a refusal stays latched until the stop request is withdrawn
`timescale 1ns/100ps
module crspc_far_model
#(
  parameter int SOCKETS = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_req_i,
  input wire logic dev_o_i,
  input wire logic dev_oe_i,
  output logic pin_o,
  output logic refused_o,
  input wire logic [SOCKETS-1:0] card_pull_i,
  input wire logic [SOCKETS-1:0] cclk_o_i,
  input wire logic [SOCKETS-1:0] cclk_oe_i,
  output logic [SOCKETS-1:0] cclk_line_o
);
  logic host_low;
  // host holds the pin low while the clock runs, floats it to ask a stop
  assign host_low = !stop_req_i || refused_o;
  // wired-and of the open-drain drivers, pull-up when all release
  assign pin_o = !(host_low || (dev_oe_i && !dev_o_i));
  assign cclk_line_o = ~(card_pull_i | (cclk_oe_i & ~cclk_o_i));
  // a low seen while asking means the device objects to the stop
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      refused_o <= 1'b0;
    else if (!stop_req_i)
      refused_o <= 1'b0;
    else if (!pin_o)
      refused_o <= 1'b1;
  end
endmodule // crspc_far_model

//--- test/crspc_power_ctrl_bench.sv
// Purpose: self-checking bench of the clock-run, suspend and card control
// Assumes: short idle and ask counts, card link clock of 6 ns
// Notes: table rows hold at most one stop reason each beside the refusal expected
`timescale 1ns/100ps
module crspc_power_ctrl_bench;
  localparam int S = 2;
  localparam int HOLD = 2;
  logic clk_i, rst_i, card_clk_i, stop_req, refused, pin_lvl;
  logic [12:0] rsn;
  logic suspend, pci_rst, glob_rst, gnt_n, txn;
  logic [S-1:0] pull, cline, ccr_oe, cdo, cen, cod, apd, idle, flt, c16r;
  logic mf_o, mf_oe, core_rst, gate, pfloat, ring_out, csc;
  int err_count, checks;
  // bit 13 expected refusal, bits 12..0 stop reasons
  logic [13:0] rows [14] = '{
    14'h0000, 14'h2001, // none, keep bit
    14'h2002, 14'h2004, 14'h2008,
    14'h2010, 14'h2020, 14'h2040, // posted, irq, probe
    14'h2080, 14'h2100, 14'h2200,
    14'h2400, 14'h2800, 14'h3000 // wake, ring, bus request
  };

  // pci and card link clocks, unrelated in phase
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    card_clk_i = 1'b0;
    #1.3;
    forever #3 card_clk_i = ~card_clk_i;
  end

  crspc_power_ctrl #(.SOCKETS(S), .HOLD_CYC(HOLD), .IDLE_CYC(8),
    .ASK_CYC(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .card_clk_i(card_clk_i),
    .keep_pci_clock_bit_i(rsn[0]), .r16_busy_i(rsn[1]),
    .cb_master_busy_i(rsn[2]), .pci_master_busy_i(rsn[3]),
    .posted_data_i(rsn[4]), .irq_pending_i(rsn[5]),
    .interrogating_i(rsn[6]), .fifo_data_i(rsn[7]),
    .mstate_busy_i(rsn[8]), .multifunction_pin_six_i(pin_lvl),
    .multifunction_pin_six_o(mf_o), .multifunction_pin_six_oe_o(mf_oe),
    .card_irq_i({S{rsn[9]}}), .card_wake_status_i({S{rsn[10]}}),
    .ring_i({S{rsn[11]}}), .ring_enable_i({S{rsn[11]}}),
    .cclkrun_i(cline), .cclkrun_o(cdo), .cclkrun_oe_o(ccr_oe),
    .creq_n_i(~{S{rsn[12]}}), .card_clk_en_o(cen),
    .card_output_disable_i(cod), .auto_card_powerdown_i(apd),
    .card16_idle_i(idle), .card16_float_o(flt), .card16_reset_o(c16r),
    .suspend_i(suspend), .pci_reset_in_i(pci_rst),
    .global_reset_in_i(glob_rst),
    .gnt_n_i(gnt_n), .pci_txn_i(txn), .core_reset_o(core_rst),
    .pci_clk_gate_o(gate), .pci_out_float_o(pfloat),
    .ring_wake_out_o(ring_out), .csc_async_o(csc)
  );

  crspc_far_model #(.SOCKETS(S)) far (
    .clk_i(clk_i), .rst_i(rst_i), .stop_req_i(stop_req), .dev_o_i(mf_o),
    .dev_oe_i(mf_oe), .pin_o(pin_lvl), .refused_o(refused),
    .card_pull_i(pull), .cclk_o_i(cdo), .cclk_oe_i(ccr_oe),
    .cclk_line_o(cline)
  );

  // counts a comparison and reports a mismatch at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // asks for a stop and counts the cycles the device pulls the pin low
  task automatic try_stop(input logic exp);
    logic [7:0] n;
    n = 8'h00;
    stop_req <= 1'b1;
    repeat (12)
    begin
      @(posedge clk_i);
      if (mf_oe === 1'b1)
        n = n + 8'h01;
    end
    chk(refused, exp);
    chk(n, exp ? 8'(HOLD) : 8'h00);
    chk(mf_o, 1'b0);
    stop_req <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // bounded wait until both card clocks are stopped
  task automatic wait_stopped();
    int k;
    k = 0;
    while (cen !== 2'b00 && k < 200)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k == 200)
    begin
      err_count++;
      tally_and_finish();
    end
    repeat (8) @(posedge clk_i);
  endtask

  initial
  begin
    err_count = 0;
    checks = 0;
    rst_i = 1'b1;
    stop_req = 1'b0;
    rsn = 13'h0000;
    {suspend, pci_rst, glob_rst, txn} = 4'h0;
    gnt_n = 1'b1;
    {pull, cod, apd, idle} = 8'h00;
    repeat (10) @(posedge clk_i);
    chk(core_rst, 1'b1);
    chk({mf_oe, cen, ccr_oe}, 8'h0f);
    rst_i <= 1'b0;
    // idle cards get their clocks stopped through the clock-run line
    wait_stopped();
    chk({cen, ccr_oe}, 8'h00);
    // one stop reason at a time
    foreach (rows[i])
    begin
      rsn <= rows[i][12:0];
      repeat (6) @(posedge clk_i);
      try_stop(rows[i][13]);
      rsn <= 13'h0000;
      wait_stopped();
    end
    // card restarts its own clock, which then keeps the pci clock
    pull <= 2'b10;
    repeat (10) @(posedge clk_i);
    chk(cen[1], 1'b1);
    chk(ccr_oe[1], 1'b1);
    chk(cdo, 2'b00);
    pull <= 2'b00;
    try_stop(1'b1);
    wait_stopped();
    // output disable floats and resets, auto powerdown only floats
    cod <= 2'b01;
    apd <= 2'b10;
    idle <= 2'b10;
    repeat (3) @(posedge clk_i);
    chk(flt, 2'b11);
    chk(c16r, 2'b01);
    idle <= 2'b00;
    repeat (3) @(posedge clk_i);
    chk(flt, 2'b01);
    {cod, apd} <= 4'h0;
    // each reset input reaches the core when not suspended
    for (int i = 0; i < 2; i++)
    begin
      {glob_rst, pci_rst} <= 2'b01 << i;
      repeat (6) @(posedge clk_i);
      chk(core_rst, 1'b1);
      {glob_rst, pci_rst} <= 2'b00;
      repeat (6) @(posedge clk_i);
      chk(core_rst, 1'b0);
    end
    // suspend gates clock and resets, clockless paths stay alive
    suspend <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({gate, pfloat}, 2'b11);
    {glob_rst, pci_rst} <= 2'b11;
    rsn <= 13'h0c00;
    repeat (6) @(posedge clk_i);
    chk(core_rst, 1'b0);
    chk(ring_out, 1'b1);
    chk(csc, 1'b1);
    {glob_rst, pci_rst} <= 2'b00;
    rsn <= 13'h0000;
    repeat (6) @(posedge clk_i);
    suspend <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({gate, pfloat}, 2'b00);
    // a granted transaction defers the float and the gating
    gnt_n <= 1'b0;
    txn <= 1'b1;
    suspend <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({gate, pfloat}, 2'b00);
    txn <= 1'b0;
    gnt_n <= 1'b1; // bus not left parked here
    repeat (6) @(posedge clk_i);
    chk({gate, pfloat}, 2'b11);
    suspend <= 1'b0;
    repeat (6) @(posedge clk_i);
    // a second reset in mid-run brings every output back to rest
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({mf_oe, cen, ccr_oe, core_rst}, 8'h1f);
    rst_i <= 1'b0;
    wait_stopped();
    chk({cen, ccr_oe, core_rst}, 8'h00);
    tally_and_finish();
  end
endmodule // crspc_power_ctrl_bench
